// ### rtl/daic_consts.vh
`ifndef DAIC_CONSTS_VH
`define DAIC_CONSTS_VH
`define DAIC_RES_W         12
`define DAIC_CODE_MSB      12'h800
`define DAIC_CNT_W         5
`define DAIC_EDGE_MIN      5'h02
`define DAIC_EDGE_AWAKE    5'h0A
`define DAIC_EDGE_DONE     5'h0E
`define DAIC_EDGE_SAT      5'h1F
`define DAIC_PIN_IDLE      7'h01
`define DAIC_ADDR_SE_LAST  3'h5
`define DAIC_SEL_GROUND    3'h0
`define DAIC_PWR_NORMAL    2'h0
`define DAIC_PWR_PARTIAL   2'h1
`define DAIC_PWR_FULL      2'h2
`define DAIC_OFS_CTRL      4'h0
`define DAIC_OFS_STATUS    4'h4
`define DAIC_OFS_RESULT    4'h8
`define DAIC_CTRL_RST      32'h0000_0001
`define DAIC_RESP_OKAY     2'h0
`define DAIC_RESP_SLVERR   2'h2
`endif

// ### rtl/daic_coder.v
`timescale 1ns/1ps
`include "daic_consts.vh"
module daic_coder #(
  parameter RES_W = `DAIC_RES_W
) (
  // clock and reset
  input  wire             sys_clk_in,
  input  wire             reset_in,
  // raw converter word, offset binary
  input  wire             load_in,
  input  wire [RES_W-1:0] raw_in,
  input  wire             twos_in,
  // formatted result
  output reg  [RES_W-1:0] result_out
);
  // converter steps one LSB per code, so flipping the msb is the only change
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      result_out <= {RES_W{1'b0}};
    end else if (load_in) begin
      result_out <= twos_in ? (raw_in ^ `DAIC_CODE_MSB) : raw_in;
    end
  end
endmodule

// ### rtl/daic_ctrl.v
`timescale 1ns/1ps
`include "daic_consts.vh"
module daic_ctrl #(
  parameter RES_W = `DAIC_RES_W
) (
  // clock and reset
  input  wire             sys_clk_in,
  input  wire             reset_in,
  // host control pins
  input  wire             conv_strobe_n_in,
  input  wire             sclk_in,
  input  wire             input_config_select_in,
  input  wire             chan_addr_bit0_in,
  input  wire             chan_addr_bit1_in,
  input  wire             chan_addr_bit2_in,
  input  wire             span_select_in,
  // raw converter words
  input  wire             raw_valid_in,
  input  wire [RES_W-1:0] raw_first_in,
  input  wire [RES_W-1:0] raw_second_in,
  // multiplexer and analog control
  output reg  [2:0]       mux_pos_sel_out,
  output reg  [2:0]       mux_neg_sel_out,
  output reg              single_ended_out,
  output reg              pseudo_diff_out,
  output reg              span_double_out,
  output reg              twos_comp_out,
  output reg              addr_undefined_out,
  output reg  [1:0]       power_mode_out,
  // result words and data pin enables
  output wire [RES_W-1:0] result_out_first,
  output wire [RES_W-1:0] result_out_second,
  output wire             result_oe_out,
  // axi4-lite slave
  input  wire [3:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [3:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready
);
  localparam CNT_W = `DAIC_CNT_W;
  // strobe idles high, so its synchroniser stages reset high
  localparam [6:0] PIN_IDLE = `DAIC_PIN_IDLE;

  // pin synchronisers, stage one read only by stage two
  reg  [6:0] pin_meta_r;
  reg  [6:0] pin_sync_r;
  reg        strobe_d_r;
  reg        sclk_d_r;
  wire       strobe_n  = pin_sync_r[0];
  wire       sclk_s    = pin_sync_r[1];
  wire       strobe_fall = strobe_d_r & ~strobe_n;
  wire       strobe_rise = ~strobe_d_r & strobe_n;
  wire       sclk_fall   = sclk_d_r & ~sclk_s;

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_meta_r <= PIN_IDLE;
      pin_sync_r <= PIN_IDLE;
      strobe_d_r <= 1'b1;
      sclk_d_r   <= 1'b0;
    end else begin
      pin_meta_r <= {span_select_in, chan_addr_bit2_in, chan_addr_bit1_in,
                     chan_addr_bit0_in, input_config_select_in, sclk_in, conv_strobe_n_in};
      pin_sync_r <= pin_meta_r;
      strobe_d_r <= strobe_n;
      sclk_d_r   <= sclk_s;
    end
  end

  // software control and conversion tracking
  reg        capture_en_r;
  reg        conv_ok_r;
  reg [CNT_W-1:0] edge_cnt_r;

  // early rise window that forces power-down
  function in_pd_window;
    input [CNT_W-1:0] cnt;
    begin
      in_pd_window = (cnt >= `DAIC_EDGE_MIN) && (cnt < `DAIC_EDGE_AWAKE);
    end
  endfunction

  // low long enough to count as a full wake
  function is_awake;
    input [CNT_W-1:0] cnt;
    begin
      is_awake = (cnt >= `DAIC_EDGE_AWAKE);
    end
  endfunction

  // settings pipeline: pending from this fall, active for this conversion
  reg [4:0] pend_r;
  reg [4:0] act_r;
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      pend_r <= 5'h00;
      act_r  <= 5'h00;
    end else if (strobe_fall && capture_en_r) begin
      act_r  <= pend_r;
      pend_r <= pin_sync_r[6:2];
    end
  end
  // held until the next fall, pin motion mid-conversion is ignored

  // channel decode, one address for both multiplexers
  wire       cfg_se   = act_r[0];
  wire [2:0] cfg_addr = act_r[3:1];
  wire       cfg_span = act_r[4];
  always @* begin
    single_ended_out   = cfg_se;
    span_double_out    = cfg_span;
    mux_pos_sel_out    = `DAIC_SEL_GROUND;
    mux_neg_sel_out    = `DAIC_SEL_GROUND;
    pseudo_diff_out    = 1'b0;
    addr_undefined_out = 1'b0;
    if (cfg_se) begin
      if (cfg_addr > `DAIC_ADDR_SE_LAST) begin
        addr_undefined_out = 1'b1;
      end else begin
        mux_pos_sel_out = cfg_addr + 3'h1;
      end
    end else begin
      if (cfg_addr[2:1] == 2'h3) begin
        addr_undefined_out = 1'b1;
      end else begin
        mux_pos_sel_out = {cfg_addr[2:1], 1'b1};
        mux_neg_sel_out = {cfg_addr[2:1], 1'b0} + 3'h2;
        pseudo_diff_out = cfg_addr[0];
      end
    end
    if (pseudo_diff_out) begin
      twos_comp_out = 1'b0;
    end else begin
      twos_comp_out = ~cfg_se | cfg_span;
    end
  end

  // power mode machine
  // fewer than two falls counts as a glitch and never powers down
  localparam PWR_NORMAL  = `DAIC_PWR_NORMAL;
  localparam PWR_PARTIAL = `DAIC_PWR_PARTIAL;
  localparam PWR_FULL    = `DAIC_PWR_FULL;
  reg [1:0] pwr_r;
  reg [1:0] pwr_nxt;
  always @* begin
    pwr_nxt = pwr_r;
    if (strobe_rise) begin
      case (pwr_r)
        PWR_NORMAL: begin
          if (in_pd_window(edge_cnt_r)) pwr_nxt = PWR_PARTIAL;
        end
        PWR_PARTIAL: begin
          if (in_pd_window(edge_cnt_r)) pwr_nxt = PWR_FULL;
          else if (is_awake(edge_cnt_r)) pwr_nxt = PWR_NORMAL;
        end
        PWR_FULL: begin
          if (is_awake(edge_cnt_r)) pwr_nxt = PWR_NORMAL;
        end
        default: pwr_nxt = PWR_NORMAL;
      endcase
    end
  end
  always @(posedge sys_clk_in) begin
    if (reset_in) pwr_r <= PWR_NORMAL;
    else          pwr_r <= pwr_nxt;
  end
  always @* power_mode_out = pwr_r;

  // sclk fall count within a conversion, saturating
  // kept after the rise so software can see where the strobe came up
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      edge_cnt_r <= {CNT_W{1'b0}};
      conv_ok_r  <= 1'b0;
    end else if (strobe_fall) begin
      edge_cnt_r <= {CNT_W{1'b0}};
      conv_ok_r  <= (pwr_r == PWR_NORMAL);     // dummy conversion after wake gives no data
    end else if (strobe_rise) begin
      conv_ok_r  <= 1'b0;                      // rise aborts and tri-states
    end else if (!strobe_n && sclk_fall && edge_cnt_r != `DAIC_EDGE_SAT) begin
      edge_cnt_r <= edge_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end
  assign result_oe_out = conv_ok_r & ~strobe_n;

  // result capture, only once fourteen clocks completed the conversion
  wire load_res = raw_valid_in & conv_ok_r & ~strobe_n
                  & (edge_cnt_r >= `DAIC_EDGE_DONE);
  wire [RES_W-1:0] raw_pair [0:1];
  wire [RES_W-1:0] res_pair [0:1];
  assign raw_pair[0] = raw_first_in;
  assign raw_pair[1] = raw_second_in;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_coder
      daic_coder #(.RES_W(RES_W)) u_coder (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .load_in    (load_res),
        .raw_in     (raw_pair[gi]),
        .twos_in    (twos_comp_out),
        .result_out (res_pair[gi])
      );
    end
  endgenerate
  assign result_out_first  = res_pair[0];
  assign result_out_second = res_pair[1];

  // axi4-lite write channel, address and data in either order
  // bvalid stalls both readies, so one write at most is in flight
  reg        aw_held_r;
  reg        w_held_r;
  reg [3:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held_r | aw_take;
  wire w_have  = w_held_r | w_take;
  wire [3:0]  wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire        wr_do   = aw_have & w_have & ~s_axi_bvalid;

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DAIC_RESP_OKAY;
      capture_en_r <= 1'b1;
    end else begin
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr == `DAIC_OFS_CTRL) begin
          s_axi_bresp <= `DAIC_RESP_OKAY;
          if (wr_strb[0]) capture_en_r <= wr_data[0];
        end else if (wr_addr == `DAIC_OFS_STATUS || wr_addr == `DAIC_OFS_RESULT) begin
          s_axi_bresp <= `DAIC_RESP_OKAY;      // read-only, write ignored
        end else begin
          s_axi_bresp <= `DAIC_RESP_SLVERR;
        end
      end else begin
        if (aw_take) aw_held_r <= 1'b1;
        if (w_take)  w_held_r  <= 1'b1;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  // rdata is registered, so rvalid follows the address by one clock
  assign s_axi_arready = ~s_axi_rvalid;
  wire [31:0] status_word = {16'h0000, edge_cnt_r, twos_comp_out, pseudo_diff_out,
                             addr_undefined_out, act_r, conv_ok_r, pwr_r};
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DAIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `DAIC_RESP_OKAY;
      case (s_axi_araddr)
        `DAIC_OFS_CTRL:   s_axi_rdata <= {31'h0000_0000, capture_en_r};
        `DAIC_OFS_STATUS: s_axi_rdata <= status_word;
        `DAIC_OFS_RESULT: s_axi_rdata <= {4'h0, res_pair[1], 4'h0, res_pair[0]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DAIC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### tb/daic_ctrl_chk.sv
`timescale 1ns/1ps
module daic_ctrl_chk (
  // clock and strobe
  input logic       sys_clk_in,
  input logic       reset_in,
  input logic       conv_strobe_n_in,
  // decode, power, pins
  input logic [2:0] mux_pos_sel_out,
  input logic [2:0] mux_neg_sel_out,
  input logic       single_ended_out,
  input logic       pseudo_diff_out,
  input logic       span_double_out,
  input logic       twos_comp_out,
  input logic       addr_undefined_out,
  input logic [1:0] power_mode_out,
  input logic       result_oe_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // six samples outlast the pin synchronisers
  sequence s_idle;
    conv_strobe_n_in [*6];
  endsequence
  sequence s_busy;
    !conv_strobe_n_in [*6];
  endsequence
  a_settings_hold: assert property (
    s_idle |=> $stable({mux_pos_sel_out, mux_neg_sel_out, single_ended_out, span_double_out}))
    else $error("settings moved while idle");
  a_power_hold: assert property (
    s_busy |=> $stable(power_mode_out)) else $error("power moved mid conversion");
  a_oe_idle: assert property (
    s_idle |-> !result_oe_out) else $error("data pins driven while idle");
  a_se_ground: assert property (
    single_ended_out |-> mux_neg_sel_out == 3'h0) else $error("single-ended negative");
  a_diff_pair: assert property (
    !single_ended_out && !addr_undefined_out
    |-> mux_pos_sel_out[0] && mux_neg_sel_out == mux_pos_sel_out + 3'h1)
    else $error("bad differential pair");
  a_pseudo_bin: assert property (
    pseudo_diff_out |-> !twos_comp_out && !single_ended_out) else $error("pseudo coding");
  a_coding_table: assert property (
    !pseudo_diff_out && !addr_undefined_out
    |-> twos_comp_out == (!single_ended_out || span_double_out)) else $error("coding");
  a_undef_none: assert property (
    addr_undefined_out |-> mux_pos_sel_out == 3'h0 && mux_neg_sel_out == 3'h0)
    else $error("undefined address selects input");
endmodule
bind daic_ctrl daic_ctrl_chk u_chk (.sys_clk_in, .reset_in, .conv_strobe_n_in,
  .mux_pos_sel_out, .mux_neg_sel_out, .single_ended_out, .pseudo_diff_out,
  .span_double_out, .twos_comp_out, .addr_undefined_out, .power_mode_out, .result_oe_out);

// ### tb/daic_host.sv
`timescale 1ns/1ps
module daic_host (
  // clock
  input  logic        sys_clk_in,
  // control pins, {config, addr2..0, span}
  output logic        strobe_n_out = 1'b1,
  output logic        sclk_out = 1'b1,
  output logic [4:0]  pins_out = 5'h00,
  // converter words
  output logic        raw_valid_out = 1'b0,
  output logic [11:0] raw_first_out = 12'h000,
  output logic [11:0] raw_second_out = 12'hFFF
);
  task automatic frame(input logic [4:0] c, input int nf, input logic [11:0] r);
    begin
      pins_out <= c;
      repeat (4) @(posedge sys_clk_in);
      strobe_n_out <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      pins_out <= ~c; // late pin moves must not leak
      repeat (nf) begin
        repeat (2) @(posedge sys_clk_in);
        sclk_out <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        sclk_out <= 1'b1;
      end
      repeat (4) @(posedge sys_clk_in);
      raw_first_out <= r;
      raw_second_out <= ~r;
      raw_valid_out <= 1'b1;
      @(posedge sys_clk_in);
      raw_valid_out <= 1'b0;
      raw_first_out <= ~r;
      raw_second_out <= r;
      repeat (2) @(posedge sys_clk_in);
      strobe_n_out <= 1'b1; // rise point picks power mode
      repeat (8) @(posedge sys_clk_in);
    end
  endtask
endmodule

// ### tb/daic_ctrl_tb_top.sv
`timescale 1ns/1ps
module daic_ctrl_tb_top;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, strobe_n, sclk, raw_valid, single_ended_out;
  logic pseudo_diff_out, span_double_out, twos_comp_out, addr_undefined_out;
  logic [4:0] pins, act = 5'h00, pend = 5'h00;
  logic [11:0] raw_a, raw_b, result_out_first, result_out_second, ef = 12'h000, es = 12'h000;
  logic [2:0] mux_pos_sel_out, mux_neg_sel_out;
  logic [1:0] power_mode_out, s_axi_rresp, rrsp, pm = 2'h0, s_axi_bresp, brsp;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  int nfs [9] = '{1, 10, 2, 14, 5, 1, 9, 3, 10};
  logic [1:0] pms [9] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
  always #5 sys_clk_in = ~sys_clk_in;
  daic_host u_host (.sys_clk_in, .strobe_n_out(strobe_n), .sclk_out(sclk), .pins_out(pins),
    .raw_valid_out(raw_valid), .raw_first_out(raw_a), .raw_second_out(raw_b));
  daic_ctrl uut (.sys_clk_in, .reset_in, .conv_strobe_n_in(strobe_n), .sclk_in(sclk),
    .input_config_select_in(pins[4]), .chan_addr_bit2_in(pins[3]),
    .chan_addr_bit1_in(pins[2]), .chan_addr_bit0_in(pins[1]), .span_select_in(pins[0]),
    .raw_valid_in(raw_valid), .raw_first_in(raw_a), .raw_second_in(raw_b),
    .mux_pos_sel_out, .mux_neg_sel_out, .single_ended_out, .pseudo_diff_out,
    .span_double_out, .twos_comp_out, .addr_undefined_out, .power_mode_out,
    .result_out_first, .result_out_second, .result_oe_out(), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    brsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // {undefined, pseudo, twos, positive, negative}
  function automatic logic [8:0] dec(input logic [4:0] c);
    logic [2:0] a;
    logic u;
    a = c[3:1];
    if (c[4]) begin
      u = (a > 3'h5);
      return {u, 1'b0, c[0], u ? 3'h0 : a + 3'h1, 3'h0};
    end
    u = (a[2:1] == 2'h3);
    return {u, a[0], ~a[0], u ? 6'h00 : {a[2:1], 1'b1, a[2:1] + 2'h1, 1'b0}};
  endfunction
  task automatic run(input logic [4:0] c, input int nf, input logic [1:0] pe, input logic cap);
    logic [8:0] d;
    logic [11:0] r;
    logic [8:0] got;
    if (cap) begin
      act = pend;
      pend = c;
    end
    d = dec(act);
    if (d[8] && nf > 13) nf = 13; // undefined coding, keep result unloaded
    r = {c, 7'h2B};
    u_host.frame(c, nf, r);
    if (pm == 2'h0 && nf > 13) begin
      ef = d[6] ? r ^ 12'h800 : r;
      es = d[6] ? ~r ^ 12'h800 : ~r;
    end
    pm = pe;
    got = {single_ended_out, span_double_out, addr_undefined_out, mux_pos_sel_out,
      mux_neg_sel_out};
    chk(32'(got), 32'({act[4], act[0], d[8], d[5:0]}));
    if (!d[8]) chk(32'({pseudo_diff_out, twos_comp_out}), 32'(d[7:6]));
    chk(32'(power_mode_out), 32'(pm));
    chk(32'({result_out_second, result_out_first}), 32'({es, ef}));
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(posedge sys_clk_in);
    chk(32'({power_mode_out, twos_comp_out, mux_pos_sel_out, mux_neg_sel_out}), 32'h04A);
    rd(4'h0);
    chk(rdat, 32'h1);
    rd(4'hC);
    chk(32'(rrsp), 32'h2);
    chk(rdat, 32'h0);
    wr(4'hC, 32'h0);
    chk(32'(brsp), 32'h2);
    for (int k = 0; k < 32; k++) run(k[4:0], 14, 2'h0, 1'b1);
    wr(4'h0, 32'h0);
    chk(32'(brsp), 32'h0);
    rd(4'h0);
    chk(rdat, 32'h0);
    run(5'h0B, 13, 2'h0, 1'b0);
    run(5'h14, 13, 2'h0, 1'b0);
    wr(4'h0, 32'h1);
    for (int i = 0; i < 9; i++) begin
      run(5'h00, nfs[i], pms[i], 1'b1);
      rd(4'h4);
      chk(32'(rdat[1:0]), 32'(pms[i]));
    end
    rd(4'h8);
    chk(rdat, {4'h0, es, 4'h0, ef});
    print_verdict;
  end
endmodule
